// [hdl/sync_serial_defines.svh]
// constants for the buffered synchronous serial port
`ifndef SYNC_SERIAL_DEFINES_SVH
`define SYNC_SERIAL_DEFINES_SVH

// ==========================================
// data buffer
`define BSS_IDX_W 5
`define BSS_BUF_DEPTH 32
`define BSS_BUF_BASE 16'hFF80
`define BSS_BUF_TOP 16'hFF9F
`define BSS_BLOCKED_RD 8'hFF

// ==========================================
// timing
`define BSS_REF_PERIOD_NS 100
`define BSS_SCK_HALF_NS 500
`define BSS_SCK_HALF_CYC ((`BSS_SCK_HALF_NS + `BSS_REF_PERIOD_NS - 1) / `BSS_REF_PERIOD_NS)
`define BSS_GAP_ONE_CYC 1
`define BSS_GAP_TWO_CYC 2
`define BSS_GAP_EIGHT_CYC 8

// ==========================================
// encodings and reset values
`define BSS_GAP_NONE 2'h0
`define BSS_GAP_ONE 2'h1
`define BSS_GAP_TWO 2'h2
`define BSS_GAP_EIGHT 2'h3
`define BSS_LAST_BIT 3'h7
`define BSS_SCK_IDLE 1'h1
`define BSS_SO_RST 1'h1
`define BSS_CS_N_RST 1'h1

`endif

// [hdl/sync_serial_pkg.sv]
// types for the buffered synchronous serial port
package sync_serial_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_LOAD = 5'h02,
        ST_SHIFT = 5'h04,
        ST_GAP = 5'h08,
        ST_EXT = 5'h10
    } state_t;

    typedef struct packed {
        logic transfer_direction;
        logic ext_clock_select;
        logic gap_interval_select;
        logic gap_length_hi;
        logic gap_length_lo;
        logic [7:0] first_buffer_index;
        logic [7:0] last_buffer_index;
        logic serial_out_pin_select;
        logic serial_in_pin_select;
        logic serial_out_open_drain;
        logic chip_select_output_select;
    } cfg_t;

    typedef struct packed {
        logic od;
        logic [7:0] data;
    } tx_word_t;

endpackage

// [hdl/buffered_sync_serial.sv]
// buffered synchronous serial port: 32-byte buffer, internal or external clock
// How it works
// R1 - software selects the serial data output pin before transmitting
// R2 - transmit output can be open-drain; chip select output when selected
// R3 - 32-byte buffer holds transmit data before and receive data after
// R4 - run starts and ends at low five bits of first and last index
// R5 - direction bit: 1 transmits, 0 receives; clock source also selectable
// R6 - gap spacing set beforehand; writing the go flag to 1 starts
// R7 - run end sets the interrupt flag and clears the go flag
// R8 - internal clock drives clock pin with data; no clock between runs
// R9 - external clock shifts data; later pulses ignored; last bit stays
// R10 - idle level write between runs changes the data output level
// R11 - buffer access during transmit sets interrupt and access error flags
// R12 - software selects the serial input pin before receiving
// R13 - internal clock receive starts at once with clock driven out
// R14 - external clock receive samples only after go; later pulses ignored
// R15 - receive buffer access sets irq, access error, overrun; overrun likewise
// R16 - transmit with internal clock may hold clock high as a gap
// R17 - gap length field enables the gap; interval bit picks 8 or 16
// R18 - completion and blocked access raise one request gated by enable
// R19 - software must not write settings while the go flag is set
// R20 - receive needs input select on and chip select output off
// R21 - lsb first; transmit changes on falling edge; receive samples rising
// R22 - gap length codes 01, 10, 11 give 1, 2, 8 clock cycles
// R23 - clearing the go flag mid-run aborts, keeping buffer and settings
// R24 - first above last wraps from top of buffer to bottom
// R25 - during a run buffer writes are dropped and reads return all ones
// R26 - chip select low for the whole transmit run including gaps
`include "sync_serial_defines.svh"

module buffered_sync_serial (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire sync_serial_pkg::cfg_t cfg,
    input wire logic go_wr,
    input wire logic go_wdata,
    input wire logic idle_level_wr,
    input wire logic idle_output_level,
    input wire logic irq_clr,
    input wire logic err_clr,
    input wire logic serial_irq_enable,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic transfer_go_flag,
    output logic serial_irq_flag,
    output logic buffer_access_error_flag,
    output logic overrun_flag,
    output logic serial_irq_req,
    input wire logic sdi_in,
    output logic sck_out,
    output logic sck_oe,
    output logic so_out,
    output logic so_oe,
    output logic cs_n_out,
    output logic cs_n_oe
);

    // ==========================================
    // declarations
    logic [7:0] mem [0:`BSS_BUF_DEPTH-1];
    sync_serial_pkg::state_t state_reg, state_next;
    logic [4:0] idx_reg, idx_next, idx_inc, mem_wa;
    logic [2:0] bit_reg, bit_next;
    logic [3:0] half_reg, half_next;
    logic [6:0] gap_reg, gap_next, gap_len;
    logic [7:0] shift_reg, shift_next, rdata_reg, rdata_next, mem_wd;
    logic par_reg, par_next, go_reg, go_next, sck_reg, sck_next, so_reg, so_next;
    logic so_oe_reg, so_oe_next, cs_n_reg, cs_n_next, hold_reg, hold_next;
    logic last_reg, last_next, seen_reg, seen_next, lksel_reg, lksel_next;
    logic irq_reg, irq_next, wt_reg, wt_next, ovr_reg, ovr_next;
    logic irq_req_reg, sck_oe_reg, cs_oe_reg, mem_we, fin, byte_end, buf_hit;
    logic sdi_s1_reg, sdi_s2_reg, st_s1_reg, st_s2_reg, st_s3_reg;
    logic en_s1_reg, en_s2_reg, en_s3_reg, start_edge, end_edge;
    sync_serial_pkg::tx_word_t txh_reg, txh_next;
    // link domain
    logic [2:0] lk_cnt_reg, lk_cnt_next;
    logic [7:0] lk_rx_reg, lk_rx_next, lk_rxh_reg, lk_rxh_next;
    logic lk_start_reg, lk_start_next, lk_end_reg, lk_end_next;
    logic lk_so_reg, lk_so_next, lk_oe_reg, lk_oe_next, lk_on_reg;
    sync_serial_pkg::tx_word_t lk_tx_reg, lk_tx_next, lk_word;

    assign buf_hit = (cpu_addr[15:5] == 11'(`BSS_BUF_BASE >> 5));
    assign idx_inc = idx_reg + 5'h1;
    assign start_edge = st_s2_reg ^ st_s3_reg;
    assign end_edge = en_s2_reg ^ en_s3_reg;

    // ==========================================
    // gap length lookup
    always_comb
    begin
        unique case ({cfg.gap_length_hi, cfg.gap_length_lo}) // R22
            `BSS_GAP_NONE: gap_len = 7'h00;
            `BSS_GAP_ONE: gap_len = 7'(`BSS_GAP_ONE_CYC * 2 * `BSS_SCK_HALF_CYC - 1);
            `BSS_GAP_TWO: gap_len = 7'(`BSS_GAP_TWO_CYC * 2 * `BSS_SCK_HALF_CYC - 1);
            `BSS_GAP_EIGHT: gap_len = 7'(`BSS_GAP_EIGHT_CYC * 2 * `BSS_SCK_HALF_CYC - 1);
        endcase
    end

    // ==========================================
    // control and shift engine
    always_comb
    begin
        state_next = state_reg;
        idx_next = idx_reg;
        bit_next = bit_reg;
        half_next = half_reg;
        gap_next = gap_reg;
        par_next = par_reg;
        shift_next = shift_reg;
        go_next = go_reg;
        sck_next = sck_reg;
        so_next = so_reg;
        cs_n_next = cs_n_reg;
        hold_next = hold_reg;
        txh_next = txh_reg;
        last_next = last_reg;
        seen_next = seen_reg;
        lksel_next = lksel_reg;
        irq_next = irq_reg;
        wt_next = wt_reg;
        ovr_next = ovr_reg;
        rdata_next = rdata_reg;
        mem_we = 1'b0;
        mem_wa = cpu_addr[4:0];
        mem_wd = cpu_wdata;
        fin = 1'b0;
        byte_end = 1'b0;
        // clears first so a same-cycle set wins
        if (irq_clr)
            irq_next = 1'b0;
        if (err_clr)
        begin
            wt_next = 1'b0;
            ovr_next = 1'b0;
        end
        if (idle_level_wr && !go_reg)
            so_next = idle_output_level; // R10
        unique case (state_reg)
            sync_serial_pkg::ST_IDLE:
                if (go_wr && go_wdata) // R6
                begin
                    go_next = 1'b1;
                    idx_next = cfg.first_buffer_index[4:0]; // R4
                    par_next = 1'b0;
                    last_next = 1'b0;
                    seen_next = 1'b0;
                    cs_n_next = !(cfg.transfer_direction && cfg.chip_select_output_select
                        && cfg.serial_in_pin_select); // R26
                    if (cfg.ext_clock_select) // R5
                    begin
                        state_next = sync_serial_pkg::ST_EXT; // R14
                        hold_next = 1'b0;
                        txh_next = {cfg.serial_out_open_drain, mem[cfg.first_buffer_index[4:0]]};
                        lksel_next = cfg.transfer_direction;
                        if (cfg.transfer_direction)
                            so_next = mem[cfg.first_buffer_index[4:0]][0];
                    end
                    else
                        state_next = sync_serial_pkg::ST_LOAD; // R13
                end
            sync_serial_pkg::ST_LOAD:
            begin
                shift_next = mem[idx_reg];
                bit_next = 3'h0;
                half_next = 4'h0;
                state_next = sync_serial_pkg::ST_SHIFT;
            end
            sync_serial_pkg::ST_SHIFT:
                if (half_reg == 4'(`BSS_SCK_HALF_CYC - 1))
                begin
                    half_next = 4'h0;
                    sck_next = !sck_reg; // R8
                    if (sck_reg)
                    begin
                        if (cfg.transfer_direction)
                            so_next = shift_reg[0]; // R21
                    end
                    else
                    begin
                        shift_next = {sdi_s2_reg, shift_reg[7:1]}; // R21
                        bit_next = bit_reg + 3'h1;
                        byte_end = (bit_reg == `BSS_LAST_BIT);
                    end
                end
                else
                    half_next = half_reg + 4'h1;
            sync_serial_pkg::ST_GAP:
                if (gap_reg == 7'h00)
                    state_next = sync_serial_pkg::ST_LOAD;
                else
                    gap_next = gap_reg - 7'h01; // R16
            sync_serial_pkg::ST_EXT:
            begin
                if (end_edge)
                begin
                    seen_next = 1'b0;
                    if (!cfg.transfer_direction)
                    begin
                        if (!seen_reg)
                            ovr_next = 1'b1; // R15
                        mem_we = 1'b1; // R14
                        mem_wa = idx_reg;
                        mem_wd = lk_rxh_reg;
                        if (idx_reg == cfg.last_buffer_index[4:0])
                            fin = 1'b1;
                        else
                            idx_next = idx_inc; // R24
                    end
                    else if (last_reg)
                    begin
                        fin = 1'b1;
                        so_next = txh_reg.data[7]; // R9
                    end
                end
                if (start_edge)
                begin
                    seen_next = 1'b1;
                    if (cfg.transfer_direction && !last_reg)
                    begin
                        if (idx_reg == cfg.last_buffer_index[4:0])
                            last_next = 1'b1;
                        else
                        begin
                            idx_next = idx_inc; // R24
                            txh_next = {cfg.serial_out_open_drain, mem[idx_inc]}; // R9
                        end
                    end
                end
            end
            default:
                state_next = sync_serial_pkg::ST_IDLE;
        endcase
        // byte boundary with the internal clock
        if (byte_end)
        begin
            par_next = !par_reg;
            if (!cfg.transfer_direction)
            begin
                mem_we = 1'b1; // R3
                mem_wa = idx_reg;
                mem_wd = shift_next;
            end
            if (idx_reg == cfg.last_buffer_index[4:0])
                fin = 1'b1;
            else
            begin
                idx_next = idx_inc; // R24
                if (cfg.transfer_direction && gap_len != 7'h00
                    && (!cfg.gap_interval_select || par_reg)) // R17
                begin
                    state_next = sync_serial_pkg::ST_GAP;
                    gap_next = gap_len;
                end
                else
                    state_next = sync_serial_pkg::ST_LOAD;
            end
        end
        if (fin || (go_wr && !go_wdata && go_reg)) // R23
        begin
            go_next = 1'b0; // R7
            state_next = sync_serial_pkg::ST_IDLE;
            hold_next = 1'b1; // R9
            cs_n_next = `BSS_CS_N_RST;
            sck_next = `BSS_SCK_IDLE; // R8
            lksel_next = 1'b0;
        end
        if (fin)
            irq_next = 1'b1; // R7
        // cpu side of the buffer
        if (buf_hit && (cpu_rd || cpu_wr))
        begin
            if (go_reg)
            begin
                irq_next = 1'b1; // R11
                wt_next = 1'b1; // R11
                if (!cfg.transfer_direction)
                    ovr_next = 1'b1; // R15
                if (cpu_rd)
                    rdata_next = `BSS_BLOCKED_RD; // R25
            end
            else
            begin
                if (cpu_rd)
                    rdata_next = mem[cpu_addr[4:0]]; // R3
                if (cpu_wr)
                    mem_we = 1'b1;
            end
        end
        so_oe_next = cfg.serial_out_pin_select && !(cfg.serial_out_open_drain && so_next); // R2
    end

    always_ff @(posedge ref_clk)
    begin
        if (mem_we)
            mem[mem_wa] <= mem_wd;
        if (!rst_n)
        begin
            state_reg <= sync_serial_pkg::ST_IDLE;
            idx_reg <= 5'h00;
            bit_reg <= 3'h0;
            half_reg <= 4'h0;
            gap_reg <= 7'h00;
            par_reg <= 1'b0;
            shift_reg <= 8'h00;
            go_reg <= 1'b0;
            sck_reg <= `BSS_SCK_IDLE;
            so_reg <= `BSS_SO_RST;
            so_oe_reg <= 1'b0;
            cs_n_reg <= `BSS_CS_N_RST;
            hold_reg <= 1'b1;
            txh_reg <= '0;
            last_reg <= 1'b0;
            seen_reg <= 1'b0;
            lksel_reg <= 1'b0;
            irq_reg <= 1'b0;
            wt_reg <= 1'b0;
            ovr_reg <= 1'b0;
            rdata_reg <= 8'h00;
            irq_req_reg <= 1'b0;
            sck_oe_reg <= 1'b0;
            cs_oe_reg <= 1'b0;
            {sdi_s1_reg, sdi_s2_reg} <= 2'h0;
            {st_s1_reg, st_s2_reg, st_s3_reg} <= 3'h0;
            {en_s1_reg, en_s2_reg, en_s3_reg} <= 3'h0;
        end
        else
        begin
            state_reg <= state_next;
            idx_reg <= idx_next;
            bit_reg <= bit_next;
            half_reg <= half_next;
            gap_reg <= gap_next;
            par_reg <= par_next;
            shift_reg <= shift_next;
            go_reg <= go_next;
            sck_reg <= sck_next;
            so_reg <= so_next;
            so_oe_reg <= so_oe_next;
            cs_n_reg <= cs_n_next;
            hold_reg <= hold_next;
            txh_reg <= txh_next;
            last_reg <= last_next;
            seen_reg <= seen_next;
            lksel_reg <= lksel_next;
            irq_reg <= irq_next;
            wt_reg <= wt_next;
            ovr_reg <= ovr_next;
            rdata_reg <= rdata_next;
            irq_req_reg <= irq_reg && serial_irq_enable; // R18
            sck_oe_reg <= !cfg.ext_clock_select; // R8
            cs_oe_reg <= cfg.chip_select_output_select && cfg.serial_in_pin_select
                && cfg.transfer_direction; // R2
            {sdi_s1_reg, sdi_s2_reg} <= {sdi_in, sdi_s1_reg};
            {st_s1_reg, st_s2_reg, st_s3_reg} <= {lk_start_reg, st_s1_reg, st_s2_reg};
            {en_s1_reg, en_s2_reg, en_s3_reg} <= {lk_end_reg, en_s1_reg, en_s2_reg};
        end
    end

    // ==========================================
    // link side, external clock, held by hold_reg between runs
    always_comb
    begin
        lk_cnt_next = lk_cnt_reg + 3'h1;
        lk_rx_next = {sdi_in, lk_rx_reg[7:1]}; // R21
        lk_rxh_next = (lk_cnt_reg == `BSS_LAST_BIT) ? lk_rx_next : lk_rxh_reg;
        lk_end_next = lk_end_reg ^ (lk_cnt_reg == `BSS_LAST_BIT);
        lk_start_next = lk_start_reg ^ (lk_cnt_reg == 3'h0);
        lk_tx_next = (lk_cnt_reg == 3'h0) ? txh_reg : lk_tx_reg;
        lk_word = (lk_cnt_reg == 3'h0) ? txh_reg : lk_tx_reg;
        lk_so_next = lk_word.data[lk_cnt_reg]; // R21
        lk_oe_next = !(lk_word.od && lk_word.data[lk_cnt_reg]); // R2
    end

    always_ff @(posedge link_clk or posedge hold_reg)
    begin
        if (hold_reg) // R14
        begin
            lk_cnt_reg <= 3'h0;
            lk_rx_reg <= 8'h00;
            lk_rxh_reg <= 8'h00;
            lk_tx_reg <= '0;
        end
        else
        begin
            lk_cnt_reg <= lk_cnt_next;
            lk_rx_reg <= lk_rx_next;
            lk_rxh_reg <= lk_rxh_next;
            lk_tx_reg <= lk_tx_next;
        end
    end

    always_ff @(posedge link_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lk_start_reg <= 1'b0;
            lk_end_reg <= 1'b0;
        end
        else if (!hold_reg)
        begin
            lk_start_reg <= lk_start_next;
            lk_end_reg <= lk_end_next;
        end
    end

    always_ff @(negedge link_clk or posedge hold_reg)
    begin
        if (hold_reg)
        begin
            lk_so_reg <= `BSS_SO_RST;
            lk_oe_reg <= 1'b0;
            lk_on_reg <= 1'b0;
        end
        else
        begin
            lk_so_reg <= lk_so_next; // R9
            lk_oe_reg <= lk_oe_next;
            lk_on_reg <= 1'b1;
        end
    end

    // ==========================================
    // outputs
    assign so_out = (lksel_reg && lk_on_reg) ? lk_so_reg : so_reg;
    assign so_oe = (lksel_reg && lk_on_reg) ? lk_oe_reg : so_oe_reg;
    assign cpu_rdata = rdata_reg;
    assign transfer_go_flag = go_reg;
    assign serial_irq_flag = irq_reg;
    assign buffer_access_error_flag = wt_reg;
    assign overrun_flag = ovr_reg;
    assign serial_irq_req = irq_req_reg;
    assign sck_out = sck_reg;
    assign sck_oe = sck_oe_reg;
    assign cs_n_out = cs_n_reg;
    assign cs_n_oe = cs_oe_reg;

    // ==========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    run_end_a: assert property (fin |=> !transfer_go_flag && serial_irq_flag) // R7
        else $error("run end did not clear go and set irq");
    blocked_read_a: assert property (go_reg && buf_hit && cpu_rd |=> cpu_rdata == 8'hFF) // R25
        else $error("blocked read not all ones");
    tx_access_a: assert property (go_reg && buf_hit && cpu_wr |=> serial_irq_flag && buffer_access_error_flag) // R11
        else $error("access in run not flagged");
    rx_access_a: assert property (go_reg && buf_hit && cpu_rd && !cfg.transfer_direction
        |=> overrun_flag) // R15
        else $error("receive access missed overrun");
    irq_gate_a: assert property (serial_irq_req |-> $past(serial_irq_flag && serial_irq_enable)) // R18
        else $error("request without enabled flag");
    cs_run_a: assert property (!cs_n_out |-> transfer_go_flag) // R26
        else $error("chip select low outside a run");
    idle_clock_a: assert property (!transfer_go_flag |-> sck_out) // R8
        else $error("clock moved between runs");
    gap_high_a: assert property (state_reg == sync_serial_pkg::ST_GAP
        |-> sck_out ##1 sck_out) // R16
        else $error("clock not high in gap");
    abort_run_a: assert property (go_wr && !go_wdata && go_reg |=> state_reg == sync_serial_pkg::ST_IDLE
        && !transfer_go_flag) // R23
        else $error("abort did not stop the run");
    idle_level_a: assert property (idle_level_wr && !go_reg && !go_wr |=> so_reg == $past(idle_output_level)) // R10
        else $error("idle level not applied");

    gap_seen_c: cover property (state_reg == sync_serial_pkg::ST_GAP ##1 state_reg == sync_serial_pkg::ST_LOAD);
    ext_done_c: cover property (state_reg == sync_serial_pkg::ST_EXT && fin);
    abort_c: cover property (go_wr && !go_wdata && go_reg);

endmodule // buffered_sync_serial

// [dv/serial_peer.sv]
// partner model: external serial peer for internal and external clock runs
module serial_peer (
    input wire logic sck_out,
    input wire logic so_out,
    input wire logic transfer_go_flag,
    input wire logic ext_start,
    input wire logic [7:0] peer_byte,
    output logic link_clk,
    output logic sdi_in,
    output logic [7:0] got_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt = 3'h0;
    wire logic clk_any = ext_start ? link_clk : sck_out;
    initial link_clk = 1'h1;
    initial sdi_in = 1'h1;
    initial got_byte = 8'h00;
    // ==========================
    // capture on rising, drive on falling, lsb first
    always @(posedge clk_any)
    begin
        got_byte <= {so_out, got_byte[7:1]};
        cnt <= cnt + 3'h1;
    end
    always @(negedge clk_any)
        sdi_in <= peer_byte[cnt];
    always @(posedge transfer_go_flag)
        cnt <= 3'h0;
    always @(negedge transfer_go_flag)
        sdi_in <= ~sdi_in;
    // ==========================
    // link clock burst of two bytes, idle high outside it
    always @(posedge ext_start)
    begin
        #433.3;
        repeat (16)
        begin
            link_clk = 1'h0;
            #62.5;
            link_clk = 1'h1;
            #62.5;
        end
    end
endmodule // serial_peer

// [dv/tb_top.sv]
// self-checking testbench for the buffered synchronous serial port
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ==========================
    // stimulus and observed signals
    logic ref_clk = '0, rst_n, go_wr = '0, go_wdata = '0, idle_level_wr = '0;
    logic idle_output_level = '1, irq_clr = '0, err_clr = '0, serial_irq_enable = '1;
    logic cpu_rd = '0, cpu_wr = '0, ext_start = '0;
    logic [15:0] cpu_addr = 16'hFF80;
    logic [7:0] cpu_wdata = 8'h00, peer_byte = 8'h96, rd, cpu_rdata, got_byte;
    sync_serial_pkg::cfg_t cfg = '0;
    logic transfer_go_flag, serial_irq_flag, buffer_access_error_flag, overrun_flag;
    logic serial_irq_req, sck_out, sck_oe, so_out, so_oe, cs_n_out, cs_n_oe, link_clk, sdi_in;
    int n_errors = 0, n_checks = 0, n_cyc = 0;
    buffered_sync_serial dut_u (.*);
    serial_peer peer_u (.*);
    always #50 ref_clk = ~ref_clk;
    // ==========================
    // shared tasks
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic acc(input logic wr, input logic [4:0] idx, input logic [7:0] d);
        @(posedge ref_clk);
        cpu_addr <= 16'hFF80 + {11'h000, idx};
        cpu_wr <= wr;
        cpu_rd <= !wr;
        cpu_wdata <= d;
        @(posedge ref_clk);
        cpu_wr <= '0;
        cpu_rd <= '0;
        cyc(1);
        rd = cpu_rdata;
    endtask
    task automatic pulse_go(input logic v);
        @(posedge ref_clk);
        go_wr <= '1;
        go_wdata <= v;
        @(posedge ref_clk);
        go_wr <= '0;
        #1;
    endtask
    task automatic wait_done;
        n_cyc = 0;
        while (transfer_go_flag !== 1'h0 && n_cyc < 3000)
        begin
            cyc(1);
            n_cyc++;
        end
        chk("go cleared", transfer_go_flag, 0);
        chk("irq flag", serial_irq_flag, 1);
    endtask
    task automatic clr;
        @(posedge ref_clk);
        irq_clr <= '1;
        err_clr <= '1;
        @(posedge ref_clk);
        irq_clr <= '0;
        err_clr <= '0;
    endtask
    task automatic setup(input logic tx, input logic ext, input logic [7:0] f, input logic [7:0] l,
        input logic [1:0] g);
        @(posedge ref_clk);
        cfg.transfer_direction <= tx;
        cfg.ext_clock_select <= ext;
        cfg.first_buffer_index <= f;
        cfg.last_buffer_index <= l;
        {cfg.gap_length_hi, cfg.gap_length_lo} <= g;
        cfg.gap_interval_select <= g[1];
        cfg.serial_out_pin_select <= tx;
        cfg.serial_in_pin_select <= '1;
        cfg.chip_select_output_select <= tx;
    endtask
    // ==========================
    // scenarios
    task automatic t_tx;
        acc(1, 31, 8'hA5);
        acc(1, 0, 8'h3C);
        setup(1, 0, 8'hFF, 8'h00, 2'h1);
        pulse_go(1);
        chk("cs low", cs_n_out, 0);
        chk("cs oe", cs_n_oe, 1);
        chk("sck oe", sck_oe, 1);
        chk("so oe", so_oe, 1);
        wait_done;
        chk("run cycles", n_cyc[7:0], 8'hAC);
        chk("last byte", got_byte, 8'h3C);
        cyc(30);
        chk("irq req", serial_irq_req, 1);
        @(posedge ref_clk);
        serial_irq_enable <= '0;
        cyc(2);
        chk("irq gated", serial_irq_req, 0);
        serial_irq_enable <= '1;
        chk("sck idle", sck_out, 1);
        chk("so last bit", so_out, 0);
        chk("cs high", cs_n_out, 1);
        @(posedge ref_clk);
        idle_level_wr <= '1;
        @(posedge ref_clk);
        idle_level_wr <= '0;
        cyc(2);
        chk("idle level", so_out, 1);
        @(posedge ref_clk);
        cfg.serial_out_open_drain <= '1;
        cyc(2);
        chk("open drain", so_oe, 0);
        cfg.serial_out_open_drain <= '0;
        clr;
    endtask
    task automatic t_block;
        acc(1, 4, 8'h81);
        setup(1, 0, 8'h04, 8'h05, 2'h3);
        pulse_go(1);
        acc(0, 4, 8'h00);
        chk("blocked read", rd, 8'hFF);
        acc(1, 4, 8'h00);
        wait_done;
        chk("access error", buffer_access_error_flag, 1);
        chk("no overrun", overrun_flag, 0);
        clr;
        acc(0, 4, 8'h00);
        chk("write dropped", rd, 8'h81);
    endtask
    task automatic t_rx;
        setup(0, 0, 8'h05, 8'h05, 2'h0);
        pulse_go(1);
        acc(0, 0, 8'h00);
        wait_done;
        chk("rx overrun", overrun_flag, 1);
        acc(0, 5, 8'h00);
        chk("rx internal", rd, 8'h96);
        clr;
        peer_byte = 8'h5A;
        setup(0, 1, 8'h02, 8'h03, 2'h0);
        pulse_go(1);
        ext_start = '1;
        wait_done;
        ext_start = '0;
        peer_byte = 8'h00;
        cyc(2);
        ext_start = '1;
        cyc(30);
        ext_start = '0;
        acc(0, 3, 8'h00);
        chk("rx external", rd, 8'h5A);
        chk("no overrun", overrun_flag, 0);
        clr;
    endtask
    task automatic t_ext_tx;
        setup(1, 1, 8'h1F, 8'h00, 2'h0);
        pulse_go(1);
        ext_start = '1;
        wait_done;
        ext_start = '0;
        chk("ext tx byte", got_byte, 8'h3C);
        chk("ext sck oe", sck_oe, 0);
        chk("ext last bit", so_out, 0);
        clr;
    endtask
    task automatic t_abort;
        setup(1, 0, 8'h00, 8'h1F, 2'h2);
        pulse_go(1);
        cyc(40);
        pulse_go(0);
        cyc(12);
        chk("aborted", transfer_go_flag, 0);
        chk("abort no irq", serial_irq_flag, 0);
        chk("sck stopped", sck_out, 1);
        acc(0, 31, 8'h00);
        chk("buffer kept", rd, 8'hA5);
    endtask
    // ==========================
    // sequence, watchdog and verdict
    task automatic final_report;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        rst_n <= '0;
        cyc(6);
        rst_n <= '1;
        cyc(1);
        t_tx;
        t_block;
        t_rx;
        t_ext_tx;
        t_abort;
        final_report;
    end
    initial
    begin
        #1000000;
        n_errors++;
        final_report;
    end
endmodule // tb_top
